// ---- logic/dmhi_ctrl.sv ----
// Purpose: Host controller for 256K-die memory modules
// Assumes: Pins synchronous to CLK; early write only
// Notes:   Serves x8, x9 and two-bank x4 modules
//
// Overview of operation
// - Board pulls each presence line high.
// - Presence means installed, never means working.
// - Unused presence line may stay unconnected.
// - Every write is an early write.
// - Write enable low before column strobe falls.
// - Address stable before each strobe falls.
// - Only one row strobe per access.
// - Refresh may strobe both banks, column high.
// - 256 row refreshes every 4 ms.
`timescale 1ns/1ns
`default_nettype none
module dmhi_ctrl #(
  parameter int unsigned REFRESH_GAP = dmhi_pkg::REFRESH_GAP_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic        REQ_WRITE,
  input  wire logic [18:0] REQ_ADDR,
  input  wire logic [8:0]  REQ_WDATA,
  output logic [8:0]       RD_DATA,
  output logic             RD_VALID,
  output logic             MODULE_SEEN,
  input  wire logic        MODULE_PRESENT_N,
  output logic [8:0]       MUX_ADDRESS,
  output logic             BANK0_ROW_STROBE_N,
  output logic             BANK1_ROW_STROBE_N,
  output logic             COLUMN_STROBE_N,
  output logic             PARITY_COLUMN_STROBE_N,
  output logic             WRITE_ENABLE_N,
  input  wire logic [7:0]  SHARED_DATA_LINES_I,
  output logic [7:0]       SHARED_DATA_LINES_O,
  output logic [7:0]       SHARED_DATA_LINES_OE,
  output logic             PARITY_DATA_IN,
  input  wire logic        PARITY_DATA_OUT
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dmhi_pkg::dmhi_state_t state_ff, nxt_state;
  logic [7:0]  cnt_ff, nxt_cnt;
  logic [31:0] rgap_ff, nxt_rgap;
  logic        rdue_ff, nxt_rdue;
  logic [8:0]  rrow_ff, nxt_rrow;
  logic [8:0]  addr_ff, nxt_addr;
  logic [8:0]  col_ff, nxt_col;
  logic        bank_ff, nxt_bank;
  logic        wr_ff, nxt_wr;
  logic [8:0]  wd_ff, nxt_wd;
  logic        ras0_ff, nxt_ras0;
  logic        bank0_row_strobe_n_ff, nxt_bank0_row_strobe_n;
  logic        cas_ff, nxt_cas;
  logic        we_ff, nxt_we;
  logic        oe_ff, nxt_oe;
  logic [8:0]  rd_ff, nxt_rd;
  logic        rdv_ff, nxt_rdv;
  logic        seen_ff, nxt_seen;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_rdue  = rdue_ff;
    nxt_rrow  = rrow_ff;
    nxt_addr  = addr_ff;
    nxt_col   = col_ff;
    nxt_bank  = bank_ff;
    nxt_wr    = wr_ff;
    nxt_wd    = wd_ff;
    nxt_ras0  = ras0_ff;
    nxt_bank0_row_strobe_n  = bank0_row_strobe_n_ff;
    nxt_cas   = cas_ff;
    nxt_we    = we_ff;
    nxt_oe    = oe_ff;
    nxt_rd    = rd_ff;
    nxt_rdv   = 1'b0;
    nxt_seen  = ~MODULE_PRESENT_N;
    nxt_rgap  = rgap_ff + 32'h00000001;
    if (cnt_ff != 8'h00)
      nxt_cnt = cnt_ff - 8'h01;
    case (state_ff)
      dmhi_pkg::ST_IDLE:
      begin
        if (rdue_ff)
        begin
          nxt_addr  = rrow_ff;
          nxt_state = dmhi_pkg::ST_REF;
          nxt_cnt   = dmhi_pkg::ROW_SETUP_CNT;
        end
        else if (REQ_VALID)
        begin
          nxt_bank  = REQ_ADDR[18];
          nxt_addr  = REQ_ADDR[17:9];
          nxt_col   = REQ_ADDR[8:0];
          nxt_wr    = REQ_WRITE;
          nxt_wd    = REQ_WDATA;
          nxt_we    = ~REQ_WRITE;
          nxt_oe    = REQ_WRITE;
          nxt_state = dmhi_pkg::ST_ROW;
          nxt_cnt   = dmhi_pkg::ROW_SETUP_CNT;
        end
      end
      dmhi_pkg::ST_ROW:
      begin
        if (cnt_ff == 8'h00)
        begin
          nxt_ras0  = bank_ff;
          nxt_bank0_row_strobe_n  = ~bank_ff;
          nxt_state = dmhi_pkg::ST_CAS;
          nxt_cnt   = dmhi_pkg::ROW_SETUP_CNT;
        end
      end
      dmhi_pkg::ST_CAS:
      begin
        if (cnt_ff == dmhi_pkg::ROW_SETUP_CNT - 8'h01)
          nxt_addr = col_ff;
        if (cnt_ff == 8'h00)
        begin
          nxt_cas   = 1'b0;
          nxt_state = dmhi_pkg::ST_HOLD;
          nxt_cnt   = dmhi_pkg::CAS_LOW_CNT;
        end
      end
      dmhi_pkg::ST_HOLD:
      begin
        if (cnt_ff == 8'h00)
        begin
          nxt_rd    = {PARITY_DATA_OUT, SHARED_DATA_LINES_I};
          nxt_rdv   = ~wr_ff;
          nxt_ras0  = 1'b1;
          nxt_bank0_row_strobe_n  = 1'b1;
          nxt_cas   = 1'b1;
          nxt_we    = 1'b1;
          nxt_oe    = 1'b0;
          nxt_state = dmhi_pkg::ST_PRE;
          nxt_cnt   = dmhi_pkg::PRECHARGE_CNT;
        end
      end
      dmhi_pkg::ST_REF:
      begin
        if (cnt_ff == 8'h00)
        begin
          if (ras0_ff)
          begin
            nxt_ras0 = 1'b0;
            nxt_bank0_row_strobe_n = 1'b0;
            nxt_cnt  = dmhi_pkg::RAS_LOW_CNT;
          end
          else
          begin
            nxt_ras0  = 1'b1;
            nxt_bank0_row_strobe_n  = 1'b1;
            nxt_rdue  = 1'b0;
            nxt_rrow  = (rrow_ff == dmhi_pkg::ROW_LAST) ? 9'h000 : rrow_ff + 9'h001;
            nxt_state = dmhi_pkg::ST_PRE;
            nxt_cnt   = dmhi_pkg::PRECHARGE_CNT;
          end
        end
      end
      dmhi_pkg::ST_PRE:
      begin
        if (cnt_ff == 8'h00)
          nxt_state = dmhi_pkg::ST_IDLE;
      end
      default:
      begin
        nxt_state = dmhi_pkg::ST_IDLE;
      end
    endcase
    // Refresh request set wins over the clear at refresh end
    if (rgap_ff >= REFRESH_GAP - 1)
    begin
      nxt_rgap = 32'h00000000;
      nxt_rdue = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_ff <= dmhi_pkg::ST_IDLE;
      cnt_ff   <= 8'h00;
      rgap_ff  <= 32'h00000000;
      rdue_ff  <= 1'b0;
      rrow_ff  <= 9'h000;
      addr_ff  <= 9'h000;
      col_ff   <= 9'h000;
      bank_ff  <= 1'b0;
      wr_ff    <= 1'b0;
      wd_ff    <= 9'h000;
      ras0_ff  <= 1'b1;
      bank0_row_strobe_n_ff  <= 1'b1;
      cas_ff   <= 1'b1;
      we_ff    <= 1'b1;
      oe_ff    <= 1'b0;
      rd_ff    <= 9'h000;
      rdv_ff   <= 1'b0;
      seen_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      rgap_ff  <= nxt_rgap;
      rdue_ff  <= nxt_rdue;
      rrow_ff  <= nxt_rrow;
      addr_ff  <= nxt_addr;
      col_ff   <= nxt_col;
      bank_ff  <= nxt_bank;
      wr_ff    <= nxt_wr;
      wd_ff    <= nxt_wd;
      ras0_ff  <= nxt_ras0;
      bank0_row_strobe_n_ff  <= nxt_bank0_row_strobe_n;
      cas_ff   <= nxt_cas;
      we_ff    <= nxt_we;
      oe_ff    <= nxt_oe;
      rd_ff    <= nxt_rd;
      rdv_ff   <= nxt_rdv;
      seen_ff  <= nxt_seen;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REQ_READY              = (state_ff == dmhi_pkg::ST_IDLE) & ~rdue_ff;
  assign RD_DATA                = rd_ff;
  assign RD_VALID               = rdv_ff;
  assign MODULE_SEEN            = seen_ff;
  assign MUX_ADDRESS            = addr_ff;
  assign BANK0_ROW_STROBE_N     = ras0_ff;
  assign BANK1_ROW_STROBE_N     = bank0_row_strobe_n_ff;
  assign COLUMN_STROBE_N        = cas_ff;
  assign PARITY_COLUMN_STROBE_N = cas_ff;
  assign WRITE_ENABLE_N         = we_ff;
  assign SHARED_DATA_LINES_O    = wd_ff[7:0];
  assign SHARED_DATA_LINES_OE   = {8{oe_ff}};
  assign PARITY_DATA_IN         = wd_ff[8];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_early_write_we: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(cas_ff) |-> $past(we_ff) == we_ff)
    else $error("write enable changed at column strobe fall");
  chk_one_row_access: assert property (@(posedge CLK) disable iff (!RESETN)
    !cas_ff |-> (ras0_ff ^ bank0_row_strobe_n_ff))
    else $error("both or no row strobes during access");
  chk_refresh_cas_high: assert property (@(posedge CLK) disable iff (!RESETN)
    (!ras0_ff && !bank0_row_strobe_n_ff) |-> cas_ff)
    else $error("column strobe low while both banks strobed");
  chk_no_drive_read: assert property (@(posedge CLK) disable iff (!RESETN)
    oe_ff |-> !we_ff || state_ff == dmhi_pkg::ST_IDLE)
    else $error("data driven outside write");
  chk_addr_stable_cas: assert property (@(posedge CLK) disable iff (!RESETN)
    !cas_ff |-> $stable(addr_ff))
    else $error("address moved while column strobe low");
  chk_refresh_due: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(rdue_ff) |-> ##[1:200] (!ras0_ff && !bank0_row_strobe_n_ff))
    else $error("refresh not started in time");
  chk_read_valid: assert property (@(posedge CLK) disable iff (!RESETN)
    RD_VALID |-> !wr_ff && we_ff)
    else $error("read data flagged on write");
  chk_parity_strobe: assert property (@(posedge CLK) disable iff (!RESETN)
    !PARITY_COLUMN_STROBE_N |-> $stable(PARITY_DATA_IN) && $stable(SHARED_DATA_LINES_O))
    else $error("write data moved while parity strobe low");
endmodule : dmhi_ctrl
`default_nettype wire

// ---- logic/dmhi_pkg.sv ----
// Purpose: Constants for the memory module controller
// Assumes: 125 MHz controller clock
// Notes:   Timing figures in ns, cycle counts derived
package dmhi_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned ROW_BITS        = 9;
  localparam int unsigned ADDR_BITS       = 18;
  localparam int unsigned DATA_BITS       = 8;
  localparam int unsigned ROW_LSB         = 9;
  localparam int unsigned REFRESH_ROWS    = 256;
  localparam int unsigned REFRESH_MS      = 4;
  localparam int unsigned ROW_SETUP_NS    = 20;
  localparam int unsigned RAS_LOW_NS      = 200;
  localparam int unsigned CAS_LOW_NS      = 100;
  localparam int unsigned PRECHARGE_NS    = 120;
  localparam int unsigned REFRESH_GAP_NS  = (REFRESH_MS * 1000000) / REFRESH_ROWS;
  localparam int unsigned ROW_SETUP_CYC   = (ROW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAS_LOW_CYC     = (RAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CAS_LOW_CYC     = (CAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRECHARGE_CYC   = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_GAP_CYC = REFRESH_GAP_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  ROW_SETUP_CNT   = 8'(ROW_SETUP_CYC);
  localparam logic [7:0]  RAS_LOW_CNT     = 8'(RAS_LOW_CYC);
  localparam logic [7:0]  CAS_LOW_CNT     = 8'(CAS_LOW_CYC);
  localparam logic [7:0]  PRECHARGE_CNT   = 8'(PRECHARGE_CYC);
  localparam logic [8:0]  ROW_LAST        = 9'h0FF;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ROW  = 3'b001,
    ST_CAS  = 3'b010,
    ST_HOLD = 3'b011,
    ST_REF  = 3'b100,
    ST_PRE  = 3'b101
  } dmhi_state_t;
endpackage : dmhi_pkg

// ---- dv/dmhi_module_model.sv ----
// Purpose: Memory module model at the far side
// Assumes: Two banks, own parity strobe
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module dmhi_module_model #(
  parameter int RD_DELAY_NS = 60
) (
  input  wire logic [8:0] mux_address,
  input  wire logic       bank0_row_strobe_n,
  input  wire logic       bank1_row_strobe_n,
  input  wire logic       column_strobe_n,
  input  wire logic       parity_column_strobe_n,
  input  wire logic       write_enable_n,
  input  wire logic [7:0] shared_data_lines,
  input  wire logic       parity_data_in,
  output logic [7:0]      data_drive,
  output logic            data_drive_en,
  output logic            parity_data_out,
  output logic            module_present_n
);
  logic [7:0] mem [int];
  logic       par [int];
  logic [8:0] row_q;
  logic       bank_q;
  logic [7:0] last_q = 8'h00;
  logic       last_p = 1'h0;
  logic       p_en   = 1'h0;
  initial data_drive_en = 1'h0;
  assign module_present_n = 1'h0;
  assign data_drive = data_drive_en ? last_q : ~last_q;
  assign parity_data_out = p_en ? last_p : ~last_p;
  always @(negedge bank0_row_strobe_n)
  begin
    row_q  = mux_address;
    bank_q = 1'h0;
  end
  always @(negedge bank1_row_strobe_n)
  begin
    row_q  = mux_address;
    bank_q = 1'h1;
  end
  always @(negedge column_strobe_n)
    if (!write_enable_n) mem[{bank_q, row_q, mux_address}] = shared_data_lines;
    else
    begin
      last_q <= #RD_DELAY_NS mem[{bank_q, row_q, mux_address}];
      data_drive_en <= #RD_DELAY_NS 1'h1;
    end
  always @(posedge column_strobe_n) data_drive_en <= 1'h0;
  always @(negedge parity_column_strobe_n)
    if (!write_enable_n) par[{bank_q, row_q, mux_address}] = parity_data_in;
    else
    begin
      last_p <= #RD_DELAY_NS par[{bank_q, row_q, mux_address}];
      p_en <= #RD_DELAY_NS 1'h1;
    end
  always @(posedge parity_column_strobe_n) p_en <= 1'h0;
endmodule : dmhi_module_model
`default_nettype wire

// ---- dv/dram_module_host_interface_tb_top.sv ----
// Purpose: Self-checking bench for the module controller
// Assumes: Short refresh gap in simulation
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module dram_module_host_interface_tb_top;
  localparam int GAP = 100;
  logic clk = 1'h0, resetn = 1'h0, req_valid = 1'h0, req_write = 1'h0, absent = 1'h0;
  logic [18:0] req_addr = 19'h00000;
  logic [8:0] req_wdata = 9'h000, rd_data, mux;
  logic req_ready, rd_valid, seen, pres_n, b0_n, b1_n, cas_n, pcas_n, we_n, pd_in, pd_out, m_en;
  logic [7:0] dq_i, dq_o, dq_oe, m_dq;
  int err_count = 0, checks_done = 0, ref_count = 0, clash = 0;
  bit seen_row [256];
  always #4 clk = ~clk;
  assign dq_i = (dq_oe & dq_o) | (~dq_oe & m_dq);
  dmhi_ctrl #(.REFRESH_GAP(GAP)) dmhi_ctrl_inst (
    .CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .MODULE_SEEN(seen), .MODULE_PRESENT_N(absent ? 1'h1 : pres_n),
    .MUX_ADDRESS(mux), .BANK0_ROW_STROBE_N(b0_n), .BANK1_ROW_STROBE_N(b1_n),
    .COLUMN_STROBE_N(cas_n), .PARITY_COLUMN_STROBE_N(pcas_n), .WRITE_ENABLE_N(we_n),
    .SHARED_DATA_LINES_I(dq_i), .SHARED_DATA_LINES_O(dq_o), .SHARED_DATA_LINES_OE(dq_oe),
    .PARITY_DATA_IN(pd_in), .PARITY_DATA_OUT(pd_out));
  dmhi_module_model dmhi_module_model_inst (
    .mux_address(mux), .bank0_row_strobe_n(b0_n), .bank1_row_strobe_n(b1_n),
    .column_strobe_n(cas_n), .parity_column_strobe_n(pcas_n), .write_enable_n(we_n),
    .shared_data_lines(dq_i), .parity_data_in(pd_in), .data_drive(m_dq),
    .data_drive_en(m_en), .parity_data_out(pd_out), .module_present_n(pres_n));
  // ----
  // Wire watchers
  // ----
  always @(negedge cas_n) if (!(b0_n ^ b1_n) || (!we_n && dq_oe !== 8'hFF)) clash++;
  always @(posedge clk) if (|dq_oe && m_en) clash++;
  always @(negedge b0_n) #1 if (b1_n === 1'h0)
  begin
    ref_count++;
    if (cas_n !== 1'h1 || mux > 9'h0FF) clash++;
    else seen_row[mux[7:0]] = 1'h1;
  end
  task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cmp_n(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_n
  task automatic access(input logic wr, input logic [18:0] a, input logic [8:0] d,
                        output logic [8:0] q);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    req_valid = 1'h1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    do @(negedge clk); while (req_ready !== 1'h1 && ++n < 300);
    cmp("request taken", 9'h001, {8'h00, req_ready});
    @(posedge clk);
    #1;
    req_valid = 1'h0;
    n = 0;
    if (!wr)
    begin
      do @(negedge clk); while (rd_valid !== 1'h1 && ++n < 60);
      cmp("read valid", 9'h001, {8'h00, rd_valid});
    end
    q = rd_data;
  endtask : access
  task automatic test_presence;
    @(posedge clk);
    #1 absent = 1'h1;
    repeat (3) @(posedge clk);
    #1;
    cmp("seen empty", 9'h000, {8'h00, seen});
    absent = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    cmp("seen fitted", 9'h001, {8'h00, seen});
    $display("test_presence done");
  endtask : test_presence
  task automatic test_rw;
    logic [18:0] a [4] = '{19'h7FFFF, 19'h3FFFF, 19'h00300, 19'h20001};
    logic [8:0]  d [4] = '{9'h1A5, 9'h05A, 9'h100, 9'h0FF};
    logic [8:0]  q;
    for (int i = 0; i < 4; i++) access(1'h1, a[i], d[i], q);
    for (int i = 0; i < 4; i++)
    begin
      access(1'h0, a[i], 9'h000, q);
      cmp("read word", d[i], q);
    end
    $display("test_rw done");
  endtask : test_rw
  task automatic test_reset;
    logic [8:0] q;
    logic [8:0] pins;
    access(1'h1, 19'h00055, 9'h155, q);
    cmp("busy drive", 9'h0FF, {req_ready, dq_oe});
    resetn = 1'h0;
    #1;
    pins = {req_ready, rd_valid, b0_n, b1_n, cas_n, pcas_n, we_n, |dq_oe, mux[0]};
    cmp("reset pins", 9'h17C, pins);
    cmp("reset addr", 9'h000, mux);
    repeat (2) @(posedge clk);
    #1 resetn = 1'h1;
    $display("test_reset done");
  endtask : test_reset
  task automatic test_refresh;
    int rows;
    logic [8:0] q;
    rows = 0;
    ref_count = 0;
    foreach (seen_row[i]) seen_row[i] = 1'h0;
    repeat (256 * GAP + 200) @(posedge clk);
    foreach (seen_row[i]) rows += seen_row[i];
    cmp_n("rows refreshed", 256, rows);
    cmp_n("enough refreshes", 1, int'(ref_count >= 256));
    access(1'h0, 19'h7FFFF, 9'h000, q);
    cmp("kept word", 9'h1A5, q);
    cmp_n("strobe clashes", 0, clash);
    $display("test_refresh done");
  endtask : test_refresh
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial
  begin
    #(8 * (256 * GAP + 4000));
    err_count++;
    test_done();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    #1 resetn = 1'h1;
    test_presence();
    test_rw();
    test_reset();
    test_refresh();
    test_done();
  end
endmodule : dram_module_host_interface_tb_top
`default_nettype wire
